/* verilog/scfg_defines.svh */
// constants of the synthesizer configuration block: register addresses,
// field positions, reset values and fastlock limits
// assumes 24-bit serial words, address in the low four bits
//
// Summary of operation
// - order code selects fourth, second, third modulator
// - order code 1 holds modulator, integer mode
// - dither code: weak, reserved, strong, disabled
// - wide fraction bit enables upper ten bits
// - halve bit divides oscillator output by two
// - timeout three or less: pin is general output
// - timeout 0..3 sets pin hiz/low/low/high
// - timeout four up: engaged twice value cycles
// - engaged: pin grounded, fast gain, fast resistors
// - steady: pin hiz, normal gain and resistors
// - fast gain code n gives n+1 units
// - loop power follows its enable bit
// - oscillator core power follows its bit
// - reference inverter power follows bit, default one
// - four regulators follow own bits, default one
// - reset bit one: defaults and power down
// - reset bit zero releases, blocks stay off
// - three-bit code picks capacitor pair
// - resistor codes select 10 to 40 kohm
// - steady gain code n gives n+1 units
`ifndef SCFG_DEFINES_SVH
`define SCFG_DEFINES_SVH

// ----------------------------------------
// serial word
// ----------------------------------------
`define SCFG_WORD_W 24
`define SCFG_ADDR_W 4
`define SCFG_ADDR_MOD 4'h3
`define SCFG_ADDR_FAST 4'h4
`define SCFG_ADDR_PWR 4'h5
`define SCFG_ADDR_LPF 4'h6

// ----------------------------------------
// modulator_config fields
// ----------------------------------------
`define SCFG_ORDER_LSB 4
`define SCFG_DITHER_LSB 6
`define SCFG_WIDE_BIT 8
`define SCFG_HALVE_BIT 9
`define SCFG_GAIN_LSB 10
// output halving exists on this option
`define SCFG_HALVE_SUPPORTED 1'b1

// ----------------------------------------
// fastlock_timing fields
// ----------------------------------------
`define SCFG_FAST_TIMEOUT_LSB 4
`define SCFG_FGAIN_LSB 18
`define SCFG_FAST_TIMEOUT_GPO_MAX 14'h0003

// ----------------------------------------
// power_enables fields
// ----------------------------------------
`define SCFG_PWR_LSB 4
`define SCFG_RRST_BIT 11

// ----------------------------------------
// loop_filter_select fields
// ----------------------------------------
`define SCFG_CAP_LSB 4
`define SCFG_RAF_LSB 7
`define SCFG_RA_LSB 9
`define SCFG_RBF_LSB 11
`define SCFG_RB_LSB 13

// ----------------------------------------
// reset values
// ----------------------------------------
`define SCFG_MOD_RST 24'h000000
`define SCFG_FAST_RST 24'h000000
`define SCFG_PWR_RST 24'h0007c0
`define SCFG_LPF_RST 24'h000000

`endif

/* verilog/scfg_pkg.sv */
// types of the synthesizer configuration block
// assumes scfg_defines.svh is on the include path
`include "scfg_defines.svh"

package scfg_pkg;

   // ----------------------------------------
   // modes
   // ----------------------------------------
   typedef enum logic [1:0] {
      SCFG_ORD4 = 2'b00,
      SCFG_ORD_HOLD = 2'b01,
      SCFG_ORD2 = 2'b10,
      SCFG_ORD3 = 2'b11
   } scfg_order_t;

   typedef enum logic [1:0] {
      SCFG_DITH_WEAK = 2'b00,
      SCFG_DITH_RSVD = 2'b01,
      SCFG_DITH_STRONG = 2'b10,
      SCFG_DITH_OFF = 2'b11
   } scfg_dither_t;

   // three-write initialisation stage
   typedef enum logic [1:0] {
      SCFG_ST_RESET = 2'b00,
      SCFG_ST_RELEASED = 2'b01,
      SCFG_ST_RUN = 2'b10
   } scfg_init_t;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic [`SCFG_WORD_W-1:0] data;
      logic valid;
   } scfg_word_t;

   typedef struct packed {
      logic level;
      logic drive_en;
   } scfg_pin_t;

   typedef struct packed {
      scfg_order_t order;
      logic mod_hold;
      scfg_dither_t dither;
      logic wide_fraction_mode;
      logic output_halve;
   } scfg_mod_t;

   typedef struct packed {
      logic fast_active;
      logic [4:0] pump_mult;
      logic [5:0] res_a_kohm;
      logic [5:0] res_b_kohm;
      logic [7:0] cap_a_pf;
      logic [7:0] cap_b_pf;
   } scfg_loop_t;

   typedef struct packed {
      logic pll_on;
      logic osc_core_power_on;
      logic ref_inverter_power_on;
      logic osc_regulator_on;
      logic loop_regulator_a_on;
      logic loop_regulator_b_on;
      logic digital_regulator_on;
   } scfg_pwr_t;

   // ----------------------------------------
   // module state
   // ----------------------------------------
   typedef struct packed {
      logic [`SCFG_WORD_W-1:0] shift;
   } scfg_lnk_st_t;

   typedef struct packed {
      logic le_s1;
      logic le_s2;
      logic le_s3;
      scfg_word_t word;
   } scfg_rx_st_t;

endpackage : scfg_pkg

/* verilog/scfg_link_rx.sv */
// serial receiver of the configuration block
// assumes the host stops the link clock before raising latch
`timescale 1ns/1ps
`default_nettype none
`include "scfg_defines.svh"

module scfg_link_rx (
   // system side
   input wire logic i_clk,
   input wire logic i_srst,
   // serial link
   input wire logic i_link_clk,
   input wire logic i_link_data,
   input wire logic i_link_latch,
   // latched word, one-cycle valid
   output scfg_pkg::scfg_word_t o_word
);
   import scfg_pkg::*;

   // ----------------------------------------
   // link domain shifter
   // ----------------------------------------
   scfg_lnk_st_t l_r; // link state
   scfg_lnk_st_t l_nxt; // its next value

   // msb first; no reset, pure data path
   always_comb begin
      l_nxt = l_r;
      l_nxt.shift = {l_r.shift[`SCFG_WORD_W-2:0], i_link_data};
   end

   always_ff @(posedge i_link_clk) begin
      l_r <= l_nxt;
   end

   // ----------------------------------------
   // system domain latch capture
   // ----------------------------------------
   scfg_rx_st_t s_r; // system state
   scfg_rx_st_t s_nxt; // its next value

   // latch is a level crossed by two flops; the shifter is
   // quiet by then, so reading it on the latch edge is safe
   always_comb begin
      s_nxt = s_r;
      s_nxt.le_s1 = i_link_latch;
      s_nxt.le_s2 = s_r.le_s1;
      s_nxt.le_s3 = s_r.le_s2;
      s_nxt.word.valid = 1'b0;
      if (s_r.le_s2 && !s_r.le_s3) begin
         s_nxt.word.data = l_r.shift;
         s_nxt.word.valid = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_word = s_r.word;

endmodule : scfg_link_rx

`default_nettype wire

/* verilog/scfg_config_top.sv */
// configuration logic of a fractional-N synthesizer: register
// bank written over the three-wire link, fastlock timer, power
// gating and loop filter decode
// assumes the phase detector clock arrives as a pin and the
// latch pin rises only after the last link clock of a word
`timescale 1ns/1ps
`default_nettype none
`include "scfg_defines.svh"

module scfg_config_top (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // serial link
   input wire logic i_link_clk,
   input wire logic i_link_data,
   input wire logic i_link_latch,
   // phase detector clock pin
   input wire logic i_pd_clk,
   // fastlock pin
   output scfg_pkg::scfg_pin_t o_fast_pin,
   // modulator controls
   output scfg_pkg::scfg_mod_t o_mod,
   // loop controls
   output scfg_pkg::scfg_loop_t o_loop,
   // power enables
   output scfg_pkg::scfg_pwr_t o_pwr,
   // initialisation stage
   output scfg_pkg::scfg_init_t o_init_stage
);
   import scfg_pkg::*;

   // ----------------------------------------
   // decode functions
   // ----------------------------------------

   // resistor code to kilohm
   function automatic logic [5:0] res_kohm(
      input logic [1:0] code
   );
      logic [5:0] v;
      v = 6'h0a;
      case (code)
         2'h0: v = 6'h0a; // 10
         2'h1: v = 6'h14; // 20
         2'h2: v = 6'h1e; // 30
         default: v = 6'h28; // 40
      endcase
      return v;
   endfunction : res_kohm

   // capacitor code to picofarad pair
   function automatic logic [15:0] cap_pf(
      input logic [2:0] code
   );
      logic [15:0] v;
      v = 16'h3232;
      case (code)
         3'h0: v = {8'h32, 8'h32}; // 50/50
         3'h1: v = {8'h32, 8'h64}; // 50/100
         3'h2: v = {8'h32, 8'h96}; // 50/150
         3'h3: v = {8'h64, 8'h32}; // 100/50
         3'h4: v = {8'h96, 8'h32}; // 150/50
         3'h5: v = {8'h64, 8'h64}; // 100/100
         default: v = {8'h32, 8'h96}; // 50/150
      endcase
      return v;
   endfunction : cap_pf

   // gain code to unit multiple
   function automatic logic [4:0] gain_mult(
      input logic [3:0] code
   );
      return {1'b0, code} + 5'h01;
   endfunction : gain_mult

   // ----------------------------------------
   // serial receiver
   // ----------------------------------------
   scfg_word_t word; // latched word pulse

   scfg_link_rx u_rx (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_link_clk(i_link_clk),
      .i_link_data(i_link_data),
      .i_link_latch(i_link_latch),
      .o_word(word)
   );

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic pd_s1; // first sync flop
      logic pd_s2; // second sync flop
      logic pd_s3; // edge history
      logic [`SCFG_WORD_W-1:0] mod_r; // modulator_config
      logic [`SCFG_WORD_W-1:0] fast_r; // fastlock_timing
      logic [`SCFG_WORD_W-1:0] pwr_r; // power_enables
      logic [`SCFG_WORD_W-1:0] lpf_r; // loop_filter_select
      scfg_init_t stage; // initialisation stage
      logic [14:0] cnt; // fastlock cycles left
      scfg_pin_t pin; // registered pin
      scfg_mod_t mod; // registered modulator out
      scfg_loop_t loop; // registered loop out
      scfg_pwr_t pwr; // registered power out
   } scfg_top_st_t;

   scfg_top_st_t st_r; // current state
   scfg_top_st_t st_nxt; // next state

   // reset image: defaults, part held down until initialised
   localparam scfg_top_st_t ST_RST = '{
      pd_s1: 1'b0,
      pd_s2: 1'b0,
      pd_s3: 1'b0,
      mod_r: `SCFG_MOD_RST,
      fast_r: `SCFG_FAST_RST,
      pwr_r: `SCFG_PWR_RST,
      lpf_r: `SCFG_LPF_RST,
      stage: SCFG_ST_RESET,
      cnt: 15'h0000,
      pin: '0,
      mod: '0,
      loop: '0,
      pwr: '0
   };

   // ----------------------------------------
   // working signals
   // ----------------------------------------
   logic pd_tick; // one phase detector cycle
   logic [`SCFG_ADDR_W-1:0] addr; // word address
   logic wr_ok; // writes accepted
   logic [13:0] fast_timeout_count; // timeout field
   logic engaged; // fastlock active
   scfg_order_t order; // order field
   logic [1:0] sel_a; // resistor a code in use
   logic [1:0] sel_b; // resistor b code in use
   logic [3:0] gain; // pump gain in use
   logic [15:0] caps; // capacitor pair
   logic run; // blocks may be powered

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      // pd clock: two flops then edge detect on the second
      // pd must stay below half of i_clk or edges are lost
      st_nxt.pd_s1 = i_pd_clk;
      st_nxt.pd_s2 = st_r.pd_s1;
      st_nxt.pd_s3 = st_r.pd_s2;
      pd_tick = st_r.pd_s2 && !st_r.pd_s3;
      addr = word.data[`SCFG_ADDR_W-1:0];
      // while held in register reset, field writes are dropped
      wr_ok = (st_r.stage != SCFG_ST_RESET);

      // count down one per phase detector cycle; a tick on the
      // edge that reloads the count is dropped, the reload wins
      if (pd_tick && (st_r.cnt != 15'h0000)) begin
         st_nxt.cnt = st_r.cnt - 15'h0001;
      end

      if (word.valid) begin
         case (addr)
            `SCFG_ADDR_MOD: begin
               if (wr_ok) begin
                  st_nxt.mod_r = word.data;
               end
            end
            `SCFG_ADDR_FAST: begin
               if (wr_ok) begin
                  st_nxt.fast_r = word.data;
                  fast_timeout_count = word.data[`SCFG_FAST_TIMEOUT_LSB +: 14];
                  if (fast_timeout_count > `SCFG_FAST_TIMEOUT_GPO_MAX) begin
                     st_nxt.cnt = {fast_timeout_count, 1'b0};
                  end else begin
                     st_nxt.cnt = 15'h0000;
                  end
               end
            end
            `SCFG_ADDR_LPF: begin
               if (wr_ok) begin
                  st_nxt.lpf_r = word.data;
               end
            end
            `SCFG_ADDR_PWR: begin
               // honoured in every stage, so the host can always restart
               if (word.data[`SCFG_RRST_BIT]) begin
                  st_nxt.mod_r = `SCFG_MOD_RST;
                  st_nxt.fast_r = `SCFG_FAST_RST;
                  st_nxt.pwr_r = `SCFG_PWR_RST;
                  st_nxt.lpf_r = `SCFG_LPF_RST;
                  st_nxt.cnt = 15'h0000;
                  st_nxt.stage = SCFG_ST_RESET;
               end else begin
                  case (st_r.stage)
                     SCFG_ST_RESET: begin
                        st_nxt.stage = SCFG_ST_RELEASED;
                     end
                     SCFG_ST_RELEASED: begin
                        st_nxt.pwr_r = word.data;
                        st_nxt.stage = SCFG_ST_RUN;
                     end
                     SCFG_ST_RUN: begin
                        st_nxt.pwr_r = word.data;
                     end
                     default: begin
                        st_nxt.stage = SCFG_ST_RESET;
                     end
                  endcase
               end
            end
            default: begin
               // words for other blocks pass by
            end
         endcase
      end

      // ----------------------------------------
      // fastlock and pin, from the new values
      // ----------------------------------------
      // decoded from the next register image so a write and its
      // pin state land on the same edge
      fast_timeout_count = st_nxt.fast_r[`SCFG_FAST_TIMEOUT_LSB +: 14];
      if (fast_timeout_count <= `SCFG_FAST_TIMEOUT_GPO_MAX) begin
         // only code 1 keeps fastlock on for good
         engaged = (fast_timeout_count == 14'h0001);
         case (fast_timeout_count[1:0])
            2'h0: st_nxt.pin = '{level: 1'b0, drive_en: 1'b0};
            2'h1: st_nxt.pin = '{level: 1'b0, drive_en: 1'b1};
            2'h2: st_nxt.pin = '{level: 1'b0, drive_en: 1'b1};
            default: st_nxt.pin = '{level: 1'b1, drive_en: 1'b1};
         endcase
      end else begin
         engaged = (st_nxt.cnt != 15'h0000);
         st_nxt.pin = '{level: 1'b0, drive_en: engaged};
      end

      // ----------------------------------------
      // loop controls
      // ----------------------------------------
      if (engaged) begin
         gain = st_nxt.fast_r[`SCFG_FGAIN_LSB +: 4];
         sel_a = st_nxt.lpf_r[`SCFG_RAF_LSB +: 2];
         sel_b = st_nxt.lpf_r[`SCFG_RBF_LSB +: 2];
      end else begin
         gain = st_nxt.mod_r[`SCFG_GAIN_LSB +: 4];
         sel_a = st_nxt.lpf_r[`SCFG_RA_LSB +: 2];
         sel_b = st_nxt.lpf_r[`SCFG_RB_LSB +: 2];
      end
      caps = cap_pf(st_nxt.lpf_r[`SCFG_CAP_LSB +: 3]);
      st_nxt.loop.fast_active = engaged;
      st_nxt.loop.pump_mult = gain_mult(gain);
      st_nxt.loop.res_a_kohm = res_kohm(sel_a);
      st_nxt.loop.res_b_kohm = res_kohm(sel_b);
      st_nxt.loop.cap_a_pf = caps[15:8];
      st_nxt.loop.cap_b_pf = caps[7:0];

      // ----------------------------------------
      // modulator controls
      // ----------------------------------------
      order = scfg_order_t'(st_nxt.mod_r[`SCFG_ORDER_LSB +: 2]);
      st_nxt.mod.order = order;
      st_nxt.mod.mod_hold = (order == SCFG_ORD_HOLD);
      // dither mode, reserved code passed as is
      st_nxt.mod.dither =
         scfg_dither_t'(st_nxt.mod_r[`SCFG_DITHER_LSB +: 2]);
      st_nxt.mod.wide_fraction_mode =
         st_nxt.mod_r[`SCFG_WIDE_BIT] && (order != SCFG_ORD_HOLD);
      st_nxt.mod.output_halve =
         st_nxt.mod_r[`SCFG_HALVE_BIT] && `SCFG_HALVE_SUPPORTED;

      // ----------------------------------------
      // power enables, gated until initialised
      // ----------------------------------------
      // default enable bits sit in the register while gated, so the
      // third write alone decides what powers up
      run = (st_nxt.stage == SCFG_ST_RUN);
      st_nxt.pwr.pll_on = run && st_nxt.pwr_r[`SCFG_PWR_LSB];
      st_nxt.pwr.osc_core_power_on =
         run && st_nxt.pwr_r[`SCFG_PWR_LSB + 1];
      st_nxt.pwr.ref_inverter_power_on =
         run && st_nxt.pwr_r[`SCFG_PWR_LSB + 2];
      st_nxt.pwr.osc_regulator_on =
         run && st_nxt.pwr_r[`SCFG_PWR_LSB + 3];
      st_nxt.pwr.loop_regulator_a_on =
         run && st_nxt.pwr_r[`SCFG_PWR_LSB + 4];
      st_nxt.pwr.loop_regulator_b_on =
         run && st_nxt.pwr_r[`SCFG_PWR_LSB + 5];
      st_nxt.pwr.digital_regulator_on =
         run && st_nxt.pwr_r[`SCFG_PWR_LSB + 6];
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // outputs, all from flops
   // ----------------------------------------
   assign o_fast_pin = st_r.pin;
   assign o_mod = st_r.mod;
   assign o_loop = st_r.loop;
   assign o_pwr = st_r.pwr;
   assign o_init_stage = st_r.stage;

endmodule : scfg_config_top

`default_nettype wire

/* bench/scfg_host_model.sv */
// host controller on the three-wire link, a partner model for the bench
// assumes the caller lets each word finish before sending the next
`timescale 1ns/1ps
`default_nettype none

module scfg_host_model (
   // serial link driven toward the device
   output logic o_link_clk,
   output logic o_link_data,
   output logic o_link_latch
);
   // link clock stands still low between frames
   initial begin
      o_link_clk = 1'b0;
      o_link_data = 1'b0;
      o_link_latch = 1'b0;
   end

   // ----------------------------------------
   // one word, msb first, 6 ns link clock
   // ----------------------------------------
   // slow_ns stretches the stop before latch, a slow host
   task automatic send_word(input logic [23:0] w, input int slow_ns);
      for (int i = 23; i >= 0; i--) begin
         o_link_data = w[i];
         #3 o_link_clk = 1'b1;
         #3 o_link_clk = 1'b0;
      end
      // released data shows the inverse so a stale bit cannot pass
      o_link_data = ~w[0];
      #(10 + slow_ns) o_link_latch = 1'b1;
      #24 o_link_latch = 1'b0;
      #16;
   endtask : send_word
endmodule : scfg_host_model

`default_nettype wire

/* bench/scfg_config_top_assertions.sv */
// output checker of the configuration block
// assumes it is bound to scfg_config_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none

module scfg_config_top_assertions (
   // clock, reset and latch pin
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_link_latch,
   // watched outputs
   input wire scfg_pkg::scfg_pin_t o_fast_pin,
   input wire scfg_pkg::scfg_mod_t o_mod,
   input wire scfg_pkg::scfg_loop_t o_loop,
   input wire scfg_pkg::scfg_pwr_t o_pwr,
   input wire scfg_pkg::scfg_init_t o_init_stage
);
   import scfg_pkg::*;
   // single domain, so one clocking and one disable
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   hold_mode_a: assert property (o_mod.mod_hold == (o_mod.order == SCFG_ORD_HOLD))
      else $error("hold flag disagrees with order code");
   hold_integer_a: assert property (o_mod.mod_hold |-> !o_mod.wide_fraction_mode)
      else $error("wide fraction active while modulator held");
   fast_pin_low_a: assert property (o_loop.fast_active
      |-> o_fast_pin.drive_en && !o_fast_pin.level)
      else $error("fastlock active without pin driven low");
   pin_high_gpo_a: assert property (o_fast_pin.drive_en && o_fast_pin.level
      |-> !o_loop.fast_active)
      else $error("pin driven high during fastlock");
   gain_range_a: assert property (o_init_stage == SCFG_ST_RUN
      |-> o_loop.pump_mult inside {[5'h01:5'h10]})
      else $error("pump multiple out of range");
   res_code_a: assert property (o_init_stage == SCFG_ST_RUN
      |-> o_loop.res_b_kohm inside {6'h0a, 6'h14, 6'h1e, 6'h28})
      else $error("resistor value not a decoded step");
   power_gate_a: assert property (o_init_stage != SCFG_ST_RUN |-> o_pwr == '0)
      else $error("power enabled before third write");
   stage_order_a: assert property ($changed(o_init_stage)
      && o_init_stage == SCFG_ST_RUN |-> $past(o_init_stage) == SCFG_ST_RELEASED)
      else $error("run stage entered without release");
   word_whole_a: assert property ($changed(o_mod) |-> $past(i_link_latch, 3))
      else $error("modulator fields changed without a latch");
   latch_quiet_a: assert property ($rose(i_link_latch) |=> $stable(o_pwr) [*2])
      else $error("power outputs moved before word capture");
endmodule : scfg_config_top_assertions

bind scfg_config_top scfg_config_top_assertions i_chk (
   .i_clk(i_clk), .i_srst(i_srst), .i_link_latch(i_link_latch),
   .o_fast_pin(o_fast_pin), .o_mod(o_mod), .o_loop(o_loop),
   .o_pwr(o_pwr), .o_init_stage(o_init_stage)
);

`default_nettype wire

/* bench/test_scfg_config_top.sv */
// self-checking bench of the configuration block
// assumes the host model drives the link and the bench drives pd clock
`timescale 1ns/1ps
`default_nettype none

module test_scfg_config_top;
   import scfg_pkg::*;
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   logic i_pd_clk = 1'b0;
   wire logic lk_clk;
   wire logic lk_data;
   wire logic lk_latch;
   scfg_pin_t o_fast_pin;
   scfg_mod_t o_mod;
   scfg_loop_t o_loop;
   scfg_pwr_t o_pwr;
   scfg_init_t o_init_stage;
   int err_total = 0;
   int n_compared = 0;
   // capacitor pairs per code
   logic [7:0] cap_a[8] = '{8'h32, 8'h32, 8'h32, 8'h64, 8'h96, 8'h64, 8'h32, 8'h32};
   logic [7:0] cap_b[8] = '{8'h32, 8'h64, 8'h96, 8'h32, 8'h32, 8'h64, 8'h96, 8'h96};

   always #2 i_clk = ~i_clk;

   scfg_host_model i_host (.o_link_clk(lk_clk), .o_link_data(lk_data), .o_link_latch(lk_latch));
   scfg_config_top i_dut (
      .i_clk(i_clk), .i_srst(i_srst), .i_link_clk(lk_clk), .i_link_data(lk_data),
      .i_link_latch(lk_latch), .i_pd_clk(i_pd_clk), .o_fast_pin(o_fast_pin),
      .o_mod(o_mod), .o_loop(o_loop), .o_pwr(o_pwr), .o_init_stage(o_init_stage)
   );

   // ----------------------------------------
   // shared helpers
   // ----------------------------------------
   task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // field bits go to word bits 23:4, address low
   task automatic wr(input logic [3:0] a, input logic [19:0] f);
      i_host.send_word({f, a}, 0);
      repeat (2) @(posedge i_clk);
   endtask : wr

   // exact count of pd rising edges, then let the sync settle
   task automatic pd_pulses(input int n);
      repeat (n) begin
         @(posedge i_clk);
         i_pd_clk <= 1'b1;
         repeat (4) @(posedge i_clk);
         i_pd_clk <= 1'b0;
         repeat (3) @(posedge i_clk);
      end
      repeat (6) @(posedge i_clk);
   endtask : pd_pulses

   function automatic logic [5:0] kohm(input logic [1:0] c);
      return 6'({4'h0, c} + 6'h01) * 6'h0a;
   endfunction : kohm

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   // three power writes; a slow host word before them is dropped
   task automatic t_init;
      i_host.send_word({20'h0003f, 4'h3}, 40);
      chk("mod_refused", o_mod, '0);
      wr(4'h5, 20'h00080);
      chk("stage_rst", o_init_stage, SCFG_ST_RESET);
      wr(4'h5, 20'h00000);
      chk("stage_rel", {o_init_stage, o_pwr}, {SCFG_ST_RELEASED, 7'h00});
      wr(4'h5, 20'h0007f);
      chk("stage_run", {o_init_stage, o_pwr}, {SCFG_ST_RUN, 7'h7f});
   endtask : t_init

   // each enable alone, msb of the struct is the loop enable
   task automatic t_power;
      for (int k = 0; k < 7; k++) begin
         wr(4'h5, 20'(1 << k));
         chk("pwr_bit", o_pwr, 7'h40 >> k);
      end
      wr(4'h5, 20'h0007f);
   endtask : t_power

   // every order code, legal dither codes, gain up to the top step
   task automatic t_mod;
      logic [1:0] ord;
      logic [1:0] dit;
      logic [3:0] gn;
      for (int i = 0; i < 4; i++) begin
         ord = 2'(i);
         dit = (i == 1) ? 2'h3 : 2'(i);
         gn = 4'(i * 5);
         wr(4'h3, {10'h000, gn, ord[0], 1'b1, dit, ord});
         chk("mod", o_mod, {ord, ord == 2'h1, dit, ord != 2'h1, ord[0]});
         chk("gain", o_loop.pump_mult, {1'b0, gn} + 5'h01);
      end
   endtask : t_mod

   // all capacitor codes with varied resistor codes
   task automatic t_lpf;
      logic [1:0] r;
      for (int c = 0; c < 8; c++) begin
         r = 2'(c);
         wr(4'h6, {9'h000, ~r, r + 2'h2, r, r + 2'h1, 3'(c)});
         chk("lpf", {o_loop.res_a_kohm, o_loop.res_b_kohm, o_loop.cap_a_pf, o_loop.cap_b_pf},
             {kohm(r), kohm(~r), cap_a[c], cap_b[c]});
      end
   endtask : t_lpf

   // shortest timeout, then cancel of the longest, then pin codes
   task automatic t_fast;
      wr(4'h6, {9'h000, 2'h2, 2'h0, 2'h1, 2'h3, 3'h0});
      wr(4'h4, {2'h0, 4'h7, 14'h0004});
      chk("fast_on", {o_loop[33:16], o_fast_pin},
          {1'b1, 5'h08, 6'h28, 6'h0a, 2'b01});
      pd_pulses(7);
      chk("fast_hold", o_loop.fast_active, 1'b1);
      pd_pulses(1);
      chk("steady", {o_loop[33:16], o_fast_pin.drive_en},
          {1'b0, 5'h10, 6'h14, 6'h1e, 1'b0});
      wr(4'h4, {2'h0, 4'h7, 14'h3fff});
      chk("fast_max", o_loop.fast_active, 1'b1);
      for (int t = 0; t < 4; t++) begin
         wr(4'h4, {6'h00, 14'(t)});
         chk("gpo_pin", {o_loop.fast_active, o_fast_pin.drive_en,
             o_fast_pin.drive_en & o_fast_pin.level}, {t == 1, t != 0, t == 3});
      end
   endtask : t_fast

   // reset bit from run: defaults and power down
   task automatic t_rrst;
      wr(4'h5, 20'h000ff);
      chk("rrst", {o_init_stage, o_pwr, o_mod}, {SCFG_ST_RESET, 7'h00, 7'h00});
   endtask : t_rrst

   // main sequence, reset held 20 cycles
   initial begin
      repeat (20) @(posedge i_clk);
      i_srst <= 1'b0;
      @(posedge i_clk);
      t_init();
      t_power();
      t_mod();
      t_lpf();
      t_fast();
      t_rrst();
      give_verdict();
   end

   // watchdog, well past the roughly 1700 cycles the run needs
   initial begin
      #200000;
      err_total++;
      give_verdict();
   end
endmodule : test_scfg_config_top

`default_nettype wire
